// file: logic/latch_bank.sv
// holding latch memory: one row of latches per panel, registered read data
`timescale 1ns/1ns
module latch_bank
    import table_access_pkg::*;
#(
    parameter int PANELS = PANEL_COUNT,
    parameter int ROW = ROW_WORDS
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // write side, per-lane enables
    input wire logic wr_en,
    input wire logic [$clog2(PANELS)-1:0] wr_panel,
    input wire logic [$clog2(ROW)-1:0] wr_slot,
    input wire logic [2:0] wr_lanes,
    input wire logic [WORD_W-1:0] wr_data,
    // read side for the programming engine
    input wire logic [$clog2(PANELS)-1:0] rd_panel,
    input wire logic [$clog2(ROW)-1:0] rd_slot,
    output logic [WORD_W-1:0] rd_data
);

    logic [WORD_W-1:0] mem_r [PANELS*ROW];
    logic [WORD_W-1:0] rd_data_r;

    // refuse geometries the panel and slot index cannot address
    if (PANELS < 2 || ROW < 2 || (PANELS & (PANELS - 1)) != 0 || (ROW & (ROW - 1)) != 0) begin : bad_geometry
        $error("latch_bank needs power-of-two panels and row size, at least two each");
    end

    // each lane updates only when its enable is set
    always_ff @(posedge clock) begin
        if (wr_en) begin
            for (int l = 0; l < 3; l++) begin
                if (wr_lanes[l]) begin
                    mem_r[{wr_panel, wr_slot}][l*8 +: 8] <= wr_data[l*8 +: 8];
                end
            end
        end
    end

    // registered read port
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rd_data_r <= '0;
        end else begin
            rd_data_r <= mem_r[{rd_panel, rd_slot}];
        end
    end

    assign rd_data = rd_data_r;

endmodule // latch_bank

// file: logic/table_access.sv
// table access path: reads of program space, writes to holding latches or external bus
`timescale 1ns/1ns
// Notes on behaviour
// - byte read increment by one selects middle byte
// - word write high discards source upper byte at the latches; bus write keeps it
// - word-mode post-increment adds two
// - byte write increment by one selects middle byte
// - external bus region writes drive bus data
// - nonvolatile writes only load holding latches
// - latches unmapped, reached only by table writes
// - programming starts only after core's sequence
// - latch count bounds programmable block size
// - separate latch set per panel
// - each panel latch set holds one row
// - latch set chosen from write address only
// - address is page low byte over pointer
// - pointer bit zero selects byte in byte mode
// - phantom byte reads zero, writes ignored by latches but sent on the bus
module table_access
    import table_access_pkg::*;
#(
    parameter int PANELS = PANEL_COUNT,
    parameter int ROW = ROW_WORDS
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // page register load from the core
    input wire logic page_wr,
    input wire logic [15:0] page_data,
    // table instruction from the core
    input wire logic req_valid,
    input wire table_req_t req,
    // answer to the core
    output logic rsp_valid,
    output table_rsp_t rsp,
    // program array read port (data taken in the same cycle as the address, which is presented the cycle after the request)
    output logic [ADDR_W-1:0] array_addr,
    input wire logic [WORD_W-1:0] array_data,
    // external bus write
    output logic ext_wr_valid,
    output ext_wr_t ext_wr,
    // programming engine: start after the unlock sequence, drains latches
    input wire logic prog_start,
    input wire logic [$clog2(PANELS)-1:0] prog_panel,
    input wire logic [$clog2(ROW)-1:0] prog_slot,
    output logic [WORD_W-1:0] prog_data,
    output logic prog_go,
    output logic [ADDR_W-1:0] last_wr_addr
);

    localparam int SLOT_W = $clog2(ROW);
    localparam int PAN_W = $clog2(PANELS);

    // refuse a panel field that overlaps the slot field or leaves the address
    if (PANEL_BIT < SLOT_W + 1 || PANEL_BIT + PAN_W > ADDR_W) begin : bad_panel_field
        $error("table_access panel field does not fit the address");
    end

    ////////////////////////////////////////////////////////////////////////////////
    // address helpers

    // page low byte concatenated with pointer
    function automatic logic [ADDR_W-1:0] table_addr(input logic [PAGE_W-1:0] pg, input logic [PTR_W-1:0] p);
        return {pg, p};
    endfunction

    // pointer step after an access
    function automatic logic [PTR_W-1:0] next_ptr(input table_req_t r);
        if (!r.post_inc) begin
            return r.pointer;
        end
        return r.pointer + (r.byte_mode ? BYTE_STEP : WORD_STEP);
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // state and next values

    logic [PAGE_W-1:0] page_r, page_nxt;
    logic rsp_valid_r, rsp_valid_nxt;
    logic [PTR_W-1:0] rsp_ptr_r, rsp_ptr_nxt;
    logic rd_pend_r, rd_pend_nxt;
    logic rd_high_r, rd_high_nxt;
    logic rd_byte_r, rd_byte_nxt;
    logic rd_sel_r, rd_sel_nxt;
    logic ext_valid_r, ext_valid_nxt;
    ext_wr_t ext_r, ext_nxt;
    logic [ADDR_W-1:0] arr_addr_r, arr_addr_nxt;
    logic [ADDR_W-1:0] last_r, last_nxt;
    logic go_r, go_nxt;
    logic [15:0] rsp_data_r, rsp_data_nxt;

    logic [ADDR_W-1:0] addr;
    logic is_write;
    logic lw_en;
    logic [2:0] lw_lanes;
    logic [WORD_W-1:0] lw_data;
    logic [15:0] rd_word;

    assign addr = table_addr(page_r, req.pointer);
    assign is_write = (req.op == table_write_low_op) || (req.op == table_write_high_op);

    // byte lanes of a latch write
    always_comb begin
        lw_en = 1'b0;
        lw_lanes = 3'h0;
        lw_data = '0;
        if (req_valid && is_write && addr < NVM_LIMIT) begin
            lw_en = 1'b1;
            if (req.op == table_write_low_op) begin
                lw_data = {8'h00, req.data};
                if (!req.byte_mode) begin
                    lw_lanes = 3'h3;
                end else if (req.pointer[0]) begin
                    lw_lanes = 3'h2;
                    lw_data[MID_LSB +: 8] = req.data[7:0];
                end else begin
                    lw_lanes = 3'h1;
                end
            end else begin
                // high space: only the low byte reaches a real lane
                lw_data[HIGH_LSB +: 8] = req.data[7:0];
                lw_lanes = (req.byte_mode && req.pointer[0]) ? 3'h0 : 3'h4;
            end
        end
    end

    // read data selection from the array word
    always_comb begin
        rd_word = 16'h0000;
        if (rd_high_r) begin
            if (rd_byte_r && rd_sel_r) begin
                rd_word = {8'h00, PHANTOM_VALUE};
            end else begin
                rd_word = {PHANTOM_VALUE, array_data[HIGH_LSB +: 8]};
            end
        end else if (rd_byte_r) begin
            rd_word = {8'h00, rd_sel_r ? array_data[MID_LSB +: 8] : array_data[LOW_LSB +: 8]};
        end else begin
            rd_word = array_data[15:0];
        end
    end

    // next values of the access pipeline
    always_comb begin
        page_nxt = page_r;
        rsp_valid_nxt = 1'b0;
        rsp_ptr_nxt = rsp_ptr_r;
        rd_pend_nxt = 1'b0;
        rd_high_nxt = rd_high_r;
        rd_byte_nxt = rd_byte_r;
        rd_sel_nxt = rd_sel_r;
        ext_valid_nxt = 1'b0;
        ext_nxt = ext_r;
        arr_addr_nxt = arr_addr_r;
        last_nxt = last_r;
        go_nxt = prog_start;
        rsp_data_nxt = rsp_data_r;
        if (page_wr) begin
            page_nxt = page_data[PAGE_W-1:0];
        end
        if (req_valid) begin
            rsp_ptr_nxt = next_ptr(req);
            if (is_write) begin
                rsp_valid_nxt = 1'b1;
                last_nxt = addr;
                if (addr >= EXT_BUS_BASE) begin
                    ext_valid_nxt = 1'b1;
                    ext_nxt.addr = addr;
                    ext_nxt.high_space = (req.op == table_write_high_op);
                    ext_nxt.byte_mode = req.byte_mode;
                    ext_nxt.data = req.byte_mode ? {8'h00, req.data[7:0]} : req.data;
                end
            end else begin
                rd_pend_nxt = 1'b1;
                arr_addr_nxt = {addr[ADDR_W-1:1], 1'b0};
                rd_high_nxt = (req.op == table_read_high_op);
                rd_byte_nxt = req.byte_mode;
                rd_sel_nxt = req.pointer[0];
            end
        end
        if (rd_pend_r) begin
            rsp_valid_nxt = 1'b1;
            rsp_data_nxt = rd_word;
        end
    end

    // register the access pipeline
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            page_r <= PAGE_RESET;
            rsp_valid_r <= 1'b0;
            rsp_ptr_r <= '0;
            rd_pend_r <= 1'b0;
            rd_high_r <= 1'b0;
            rd_byte_r <= 1'b0;
            rd_sel_r <= 1'b0;
            ext_valid_r <= 1'b0;
            ext_r <= '0;
            arr_addr_r <= '0;
            last_r <= '0;
            go_r <= 1'b0;
            rsp_data_r <= 16'h0000;
        end else begin
            page_r <= page_nxt;
            rsp_valid_r <= rsp_valid_nxt;
            rsp_ptr_r <= rsp_ptr_nxt;
            rd_pend_r <= rd_pend_nxt;
            rd_high_r <= rd_high_nxt;
            rd_byte_r <= rd_byte_nxt;
            rd_sel_r <= rd_sel_nxt;
            ext_valid_r <= ext_valid_nxt;
            ext_r <= ext_nxt;
            arr_addr_r <= arr_addr_nxt;
            last_r <= last_nxt;
            go_r <= go_nxt;
            rsp_data_r <= rsp_data_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // holding latches, one row per panel

    latch_bank #(.PANELS(PANELS), .ROW(ROW)) u_latches (
        .clock(clock),
        .rst(rst),
        .wr_en(lw_en),
        .wr_panel(addr[PANEL_BIT +: PAN_W]),
        .wr_slot(addr[1 +: SLOT_W]),
        .wr_lanes(lw_lanes),
        .wr_data(lw_data),
        .rd_panel(prog_panel),
        .rd_slot(prog_slot),
        .rd_data(prog_data)
    );

    // outputs
    assign rsp_valid = rsp_valid_r;
    assign rsp.data = rsp_data_r;
    assign rsp.pointer = rsp_ptr_r;
    assign array_addr = arr_addr_r;
    assign ext_wr_valid = ext_valid_r;
    assign ext_wr = ext_r;
    assign prog_go = go_r;
    assign last_wr_addr = last_r;

    ////////////////////////////////////////////////////////////////////////////////
    // checks

    word_step_a: assert property (@(posedge clock) disable iff (rst)
        req_valid && !req.byte_mode && req.post_inc |=> rsp_ptr_r == $past(req.pointer) + WORD_STEP)
        else $error("word post-increment not two");
    byte_step_a: assert property (@(posedge clock) disable iff (rst)
        req_valid && req.byte_mode && req.post_inc |=> rsp_ptr_r[0] != $past(req.pointer[0]))
        else $error("byte post-increment did not flip bit zero");
    ext_write_a: assert property (@(posedge clock) disable iff (rst)
        req_valid && is_write && addr >= EXT_BUS_BASE |=> ext_wr_valid && ext_wr.addr == $past(addr))
        else $error("external region write missing");
    nvm_latch_a: assert property (@(posedge clock) disable iff (rst)
        ext_wr_valid |-> !$past(lw_en))
        else $error("latch written on external write");
    phantom_zero_a: assert property (@(posedge clock) disable iff (rst)
        req_valid && req.op == table_read_high_op |=> ##1 rsp.data[15:8] == 8'h00)
        else $error("phantom byte not zero");
    high_discard_a: assert property (@(posedge clock) disable iff (rst)
        lw_en && req.op == table_write_high_op |-> lw_lanes[1:0] == 2'h0)
        else $error("high write touched low lanes");
    byte_lane_a: assert property (@(posedge clock) disable iff (rst)
        lw_en && req.byte_mode |-> $onehot0(lw_lanes))
        else $error("byte write touched several lanes");
    page_load_a: assert property (@(posedge clock) disable iff (rst)
        page_wr |=> addr[ADDR_W-1 -: PAGE_W] == $past(page_data[PAGE_W-1:0]))
        else $error("page not in table address");
    prog_go_a: assert property (@(posedge clock) disable iff (rst)
        prog_go |-> $past(prog_start))
        else $error("programming without start");
    read_answer_a: assert property (@(posedge clock) disable iff (rst)
        req_valid && !is_write |-> ##2 rsp_valid)
        else $error("read answer late");

    read_cov_c: cover property (@(posedge clock) req_valid && req.op == table_read_low_op && req.byte_mode);
    latch_cov_c: cover property (@(posedge clock) lw_en && lw_lanes == 3'h2);
    ext_cov_c: cover property (@(posedge clock) ext_wr_valid);
    go_cov_c: cover property (@(posedge clock) prog_go);

endmodule // table_access

// file: logic/table_access_pkg.sv
// package: table access constants, operation codes and request/response carriers
package table_access_pkg;

    // address geometry
    localparam int ADDR_W = 24;
    localparam int PTR_W = 16;
    localparam int PAGE_W = 8;
    localparam int WORD_W = 24;
    localparam int ROW_WORDS = 32;
    localparam int PANEL_COUNT = 2;
    localparam int PANEL_BIT = 12;

    // byte lane positions inside a 24-bit array word
    localparam int LOW_LSB = 0;
    localparam int MID_LSB = 8;
    localparam int HIGH_LSB = 16;

    // word step after a word-mode access, byte step after a byte-mode access
    localparam logic [PTR_W-1:0] WORD_STEP = 16'h0002;
    localparam logic [PTR_W-1:0] BYTE_STEP = 16'h0001;

    // memory map regions
    localparam logic [ADDR_W-1:0] EXT_BUS_BASE = 24'h400000;
    localparam logic [ADDR_W-1:0] NVM_LIMIT = 24'h400000;

    // page reset value and phantom byte read value
    localparam logic [PAGE_W-1:0] PAGE_RESET = 8'h00;
    localparam logic [7:0] PHANTOM_VALUE = 8'h00;

    // table operations issued by the core
    typedef enum logic [1:0] {
        table_read_low_op,
        table_read_high_op,
        table_write_low_op,
        table_write_high_op
    } table_op_t;

    // one table instruction from the core
    typedef struct packed {
        table_op_t op;
        logic byte_mode;
        logic post_inc;
        logic [PTR_W-1:0] pointer;
        logic [15:0] data;
    } table_req_t;

    // answer back to the core
    typedef struct packed {
        logic [15:0] data;
        logic [PTR_W-1:0] pointer;
    } table_rsp_t;

    // external bus write
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [15:0] data;
        logic high_space;
        logic byte_mode;
    } ext_wr_t;

endpackage

// file: verification/program_array_model.sv
// behavioural program array answering the table path read port
`timescale 1ns/1ns
module program_array_model
    import table_access_pkg::*;
(
    // word address from the table path
    input wire logic [ADDR_W-1:0] array_addr,
    // word returned for that address
    output logic [WORD_W-1:0] array_data
);
    // fixed pattern built from the address so neighbouring words always differ
    assign array_data = {array_addr[7:0] ^ 8'hC3, array_addr[15:8] ^ 8'h3C, array_addr[23:16] + 8'h11};
endmodule // program_array_model

// file: verification/table_access_bench.sv
// self-checking testbench for the table access path
`timescale 1ns/1ns
module table_access_bench;
    import table_access_pkg::*;
    logic clock = 1'h0;
    logic rst = 1'h1;
    logic page_wr = 1'h0;
    logic [15:0] page_data = 16'h0000;
    logic req_valid = 1'h0;
    table_req_t req = '0;
    logic prog_start = 1'h0;
    logic [0:0] prog_panel = 1'h0;
    logic [4:0] prog_slot = 5'h00;
    logic rsp_valid, ext_wr_valid, prog_go;
    table_rsp_t rsp;
    ext_wr_t ext_wr;
    logic [ADDR_W-1:0] array_addr, last_wr_addr;
    logic [WORD_W-1:0] array_data, prog_data;
    logic [47:0] rsp_q[$];
    ext_wr_t ext_q[$];
    logic [47:0] e;
    ext_wr_t ee;
    logic [7:0] p;
    logic [15:0] ptr, d;
    logic [23:0] w;
    int miscompares = 0;
    int num_checks = 0;

    ////////////////////////////////////////////////////////////////
    // design and far-side array
    table_access #(.PANELS(2), .ROW(32)) dut (.clock(clock), .rst(rst), .page_wr(page_wr), .page_data(page_data),
        .req_valid(req_valid), .req(req), .rsp_valid(rsp_valid), .rsp(rsp), .array_addr(array_addr),
        .array_data(array_data), .ext_wr_valid(ext_wr_valid), .ext_wr(ext_wr), .prog_start(prog_start),
        .prog_panel(prog_panel), .prog_slot(prog_slot), .prog_data(prog_data), .prog_go(prog_go),
        .last_wr_addr(last_wr_addr));
    program_array_model mem (.array_addr(array_addr), .array_data(array_data));

    // 100 MHz clock
    always #5 clock = ~clock;

    ////////////////////////////////////////////////////////////////
    // compare, report and close
    task automatic check(input string what, input logic [47:0] seen, input logic [47:0] exp);
        num_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wrap_up;
        $display("checks %0d miscompares %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // independent copy of the array pattern for expectations
    function automatic logic [23:0] word_at(input logic [23:0] a);
        return {a[7:0] ^ 8'hC3, a[15:8] ^ 8'h3C, a[23:16] + 8'h11};
    endfunction

    ////////////////////////////////////////////////////////////////
    // drivers: page load, one table instruction, latch peek
    task automatic set_page(input logic [7:0] pg);
        @(posedge clock);
        #1 page_wr = 1'h1;
        page_data = {8'hA5, pg}; // upper byte must be ignored
        @(posedge clock);
        #1 page_wr = 1'h0;
    endtask

    task automatic xfer(input table_op_t op, input logic bm, input logic pi, input logic [15:0] pt,
                        input logic [15:0] dt, input logic [15:0] mk, input logic [15:0] ex);
        logic [15:0] np;
        np = pi ? pt + (bm ? BYTE_STEP : WORD_STEP) : pt;
        rsp_q.push_back({mk, ex & mk, np});
        @(posedge clock);
        #1 req_valid = 1'h1;
        req = '{op, bm, pi, pt, dt};
        @(posedge clock);
        #1 req_valid = 1'h0;
    endtask

    task automatic peek(input logic [0:0] pn, input logic [4:0] sl, input logic [23:0] exp);
        @(posedge clock);
        #1 prog_panel = pn;
        prog_slot = sl;
        @(posedge clock);
        #1 check("latch word", prog_data, exp);
    endtask

    // bounded wait until every noted answer was seen
    task automatic drain;
        for (int i = 0; i < 50 && (rsp_q.size() + ext_q.size()) > 0; i++) @(posedge clock);
        if ((rsp_q.size() + ext_q.size()) > 0) begin
            check("answers pending", 1, 0);
            wrap_up();
        end
    endtask

    ////////////////////////////////////////////////////////////////
    // monitor: pops the oldest note whenever an answer or a bus write appears
    always @(posedge clock) begin
        if (rsp_valid === 1'h1) begin
            if (rsp_q.size() == 0) begin
                check("unexpected answer", 1, 0);
            end else begin
                e = rsp_q.pop_front();
                check("read data", rsp.data & e[47:32], e[31:16]);
                check("pointer", rsp.pointer, e[15:0]);
            end
        end
        if (ext_wr_valid === 1'h1) begin
            if (ext_q.size() == 0) begin
                check("unexpected bus write", 1, 0);
            end else begin
                ee = ext_q.pop_front();
                check("bus write", 48'(ext_wr), 48'(ee));
            end
        end
    end

    // overall time limit
    initial begin
        #500000;
        check("run time limit", 1, 0);
        wrap_up();
    end

    ////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        void'($urandom(51));
        repeat (2) @(posedge clock);
        #1 rst = 1'h0;
        check("answer after reset", rsp_valid, 0);
        // reads of every kind on random pages and pointers
        for (int i = 0; i < 4; i++) begin
            p = 8'($urandom);
            ptr = 16'($urandom) & 16'hFFFE;
            w = word_at({p, ptr});
            set_page(p);
            xfer(table_read_low_op, 1'h0, 1'h1, ptr, 16'h0000, 16'hFFFF, w[15:0]);
            xfer(table_read_high_op, 1'h0, 1'h0, ptr, 16'h0000, 16'hFFFF, {8'h00, w[23:16]});
            xfer(table_read_low_op, 1'h1, 1'h1, ptr, 16'h0000, 16'h00FF, {8'h00, w[7:0]});
            xfer(table_read_low_op, 1'h1, 1'h1, ptr | 16'h0001, 16'h0000, 16'h00FF, {8'h00, w[15:8]});
            xfer(table_read_high_op, 1'h1, 1'h0, ptr, 16'h0000, 16'h00FF, {8'h00, w[23:16]});
            xfer(table_read_high_op, 1'h1, 1'h0, ptr | 16'h0001, 16'h0000, 16'h00FF, 16'h0000);
        end
        drain();
        $display("reads done");
        // word writes to panel 0, upper source byte of the high write is junk
        set_page(8'h00);
        d = 16'($urandom);
        xfer(table_write_low_op, 1'h0, 1'h0, 16'h0108, d, 16'h0000, 16'h0000);
        xfer(table_write_high_op, 1'h0, 1'h1, 16'h0108, 16'hEE5A, 16'h0000, 16'h0000);
        xfer(table_write_low_op, 1'h0, 1'h0, 16'h0004, 16'h1234, 16'h0000, 16'h0000);
        xfer(table_write_high_op, 1'h0, 1'h0, 16'h0004, 16'h0056, 16'h0000, 16'h0000);
        peek(1'h0, 5'h04, {8'h5A, d});
        // byte writes to panel 1, same slot
        xfer(table_write_high_op, 1'h1, 1'h0, 16'h1108, 16'hFF3C, 16'h0000, 16'h0000);
        xfer(table_write_low_op, 1'h1, 1'h1, 16'h1108, 16'hFF81, 16'h0000, 16'h0000);
        xfer(table_write_low_op, 1'h1, 1'h1, 16'h1109, 16'hFF7E, 16'h0000, 16'h0000);
        xfer(table_write_high_op, 1'h1, 1'h0, 16'h1109, 16'h00C9, 16'h0000, 16'h0000);
        peek(1'h1, 5'h04, 24'h3C7E81);
        peek(1'h0, 5'h04, {8'h5A, d});
        xfer(table_write_low_op, 1'h1, 1'h0, 16'h1108, 16'h0042, 16'h0000, 16'h0000);
        peek(1'h1, 5'h04, 24'h3C7E42);
        check("last write address", last_wr_addr, 24'h001108);
        drain();
        $display("latch writes done");
        // external bus region: word and byte writes, latches untouched
        set_page(8'h40);
        d = 16'($urandom);
        ext_q.push_back('{{8'h40, 16'h0204}, d, 1'h0, 1'h0});
        xfer(table_write_low_op, 1'h0, 1'h1, 16'h0204, d, 16'h0000, 16'h0000);
        ext_q.push_back('{{8'h40, 16'h0205}, {8'h00, d[15:8]}, 1'h0, 1'h1});
        xfer(table_write_low_op, 1'h1, 1'h0, 16'h0205, {d[7:0], d[15:8]}, 16'h0000, 16'h0000);
        drain();
        peek(1'h0, 5'h02, 24'h561234);
        $display("bus writes done");
        // programming start follows only the start pulse
        check("go before start", prog_go, 0);
        @(posedge clock);
        #1 prog_start = 1'h1;
        @(posedge clock);
        #1 prog_start = 1'h0;
        check("go after start", prog_go, 1);
        @(posedge clock);
        #1 check("go one cycle", prog_go, 0);
        $display("programming start done");
        wrap_up();
    end
endmodule // table_access_bench
